// ==== prbl_pkg.sv ====
// Purpose: shared constants and source selection for the protection blocking logic
// Assumes: eight protection modules, one trip stage each, sixteen selectable sources
// Notes:   register offsets are byte addresses on a 32-bit APB slave
package prbl_pkg;
    localparam int          N_MOD = 8;
    localparam int          N_SRC = 16;
    localparam int          SEL_W = 5;

    // register byte offsets
    localparam logic [11:0] OFS_GCTRL  = 12'h000;
    localparam logic [11:0] OFS_GSEL   = 12'h004;
    localparam logic [11:0] OFS_MCTRL0 = 12'h008;
    localparam logic [11:0] OFS_REVSEL = 12'h028;
    localparam logic [11:0] OFS_STATUS = 12'h02c;

    // global control bits
    localparam int          G_PROT_EN   = 0;
    localparam int          G_BLK_PERM  = 1;
    localparam int          G_TRIP_PBLK = 2;
    localparam int          G_TRIP_PERM = 3;
    localparam int          G_WIDE_FREQ = 4;

    // global selector field positions
    localparam int          GS_BLK_A = 0;
    localparam int          GS_BLK_B = 8;
    localparam int          GS_TRIP  = 16;
    localparam int          GS_MOT   = 24;

    // per-module control bits and fields
    localparam int          M_EN       = 0;
    localparam int          M_BLK_PERM = 1;
    localparam int          M_TRIP_PBK = 2;
    localparam int          M_TRIP_PRM = 3;
    localparam int          M_MOT_BLK  = 4;
    localparam int          M_FUND     = 5;
    localparam int          M_CURRENT  = 6;
    localparam int          M_BLK_SEL  = 8;
    localparam int          M_TRIP_SEL = 16;

    // status fields
    localparam int          S_ACTIVE  = 0;
    localparam int          S_TRIP    = 8;
    localparam int          S_PROT_OK = 16;
    localparam int          S_PROT_BK = 17;

    // reset values: protection on, every module off, nothing assigned
    localparam logic [31:0] RST_GCTRL  = 32'h0000_0001;
    localparam logic [31:0] RST_GSEL   = 32'h0000_0000;
    localparam logic [31:0] RST_MCTRL  = 32'h0000_0000;
    localparam logic [4:0]  RST_REVSEL = 5'h00;

    localparam logic [4:0]  SEL_NONE = 5'h00;
    localparam logic [4:0]  SEL_MAX  = 5'h10;

    // selector 0 means no assignment; 1..16 pick digital inputs then internal signals
    function automatic logic prbl_pick(input logic [15:0] src, input logic [4:0] sel);
        logic r;
        r = 1'b0;
        if (sel != SEL_NONE && sel <= SEL_MAX) begin
            r = src[4'(sel - 5'h01)];
        end
        return r;
    endfunction
endpackage

// ==== prbl_cell.sv ====
// Purpose: blocking decision for one protection module and its trip stage
// Assumes: all inputs come from registers or synchronous pins of the parent
// Notes:   purely combinational; the parent registers both results
module prbl_cell (
    input  wire logic [31:0] i_ctrl,
    input  wire logic [15:0] i_src,
    input  wire logic        i_prot_ok,
    input  wire logic        i_mot_strt,
    input  wire logic        i_freq_out,
    input  wire logic        i_rev_il,
    input  wire logic        i_glb_trip_blk,
    input  wire logic        i_trip_dec,
    output logic             o_active,
    output logic             o_trip
);
    logic ext_block_state;
    logic ext_trip_block_input;
    logic tmp_blk;
    logic trip_blk;

    // any assignable source may block, pins or internal signals alike
    assign ext_block_state      = prbl_pkg::prbl_pick(i_src, i_ctrl[prbl_pkg::M_BLK_SEL +: 5]);  // RULE7
    assign ext_trip_block_input = prbl_pkg::prbl_pick(i_src, i_ctrl[prbl_pkg::M_TRIP_SEL +: 5]); // RULE7

    assign tmp_blk = (i_ctrl[prbl_pkg::M_BLK_PERM] & ext_block_state)                            // RULE5
                   | (i_ctrl[prbl_pkg::M_MOT_BLK] & i_mot_strt)                                 // RULE10
                   | (i_ctrl[prbl_pkg::M_FUND] & i_freq_out)                                    // RULE9
                   | (i_ctrl[prbl_pkg::M_CURRENT] & i_rev_il);                                  // RULE11

    assign o_active = i_prot_ok & i_ctrl[prbl_pkg::M_EN] & ~tmp_blk;                             // RULE2 RULE12

    assign trip_blk = i_ctrl[prbl_pkg::M_TRIP_PBK]                                              // RULE3
                    | (i_ctrl[prbl_pkg::M_TRIP_PRM] & ext_trip_block_input)                     // RULE6
                    | i_glb_trip_blk;

    assign o_trip = o_active & i_trip_dec & ~trip_blk;                                          // RULE2
endmodule

// ==== prbl_top.sv ====
// Purpose: protection blocking logic with APB configuration and registered status
// Assumes: pins synchronous to I_CLK; stage trip decisions arrive from the elements
// Notes:   every top output is a flip-flop, so outputs lag their causes by one cycle
// Functional notes
// (RULE1) global enable off stops all protection
// (RULE2) module runs only while its enable set
// (RULE3) permanent trip block suppresses stage trip
// (RULE4) global temporary block needs permit and signal
// (RULE5) module temporary block needs permit and signal
// (RULE6) trip temporary block needs permit and signal
// (RULE7) any digital input or internal signal blocks
// (RULE8) either global block input blocks everything
// (RULE9) frequency excursion blocks fundamental/harmonic elements
// (RULE10) motor start blocks only configured elements
// (RULE11) current functions also blocked by reverse interlock
// (RULE12) module active only when fully unblocked
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
module prbl_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    input  wire logic [7:0]  I_DIG_IN,
    input  wire logic [7:0]  I_INT_SIG,
    input  wire logic        I_FREQ_OK,
    input  wire logic [7:0]  I_TRIP_DEC,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic [7:0]       O_MOD_ACTIVE,
    output logic [7:0]       O_TRIP_CMD,
    output logic             O_PROT_ACTIVE,
    output logic             O_PROT_BLOCKED
);
    typedef struct packed {
        logic [31:0]      gctrl;
        logic [31:0]      gsel;
        logic [7:0][31:0] mctrl;
        logic [4:0]       rev_sel;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic [7:0]       active;
        logic [7:0]       trip;
        logic             prot_active;
        logic             prot_blocked;
    } prbl_state_t;

    prbl_state_t st_q;
    prbl_state_t st_d;

    logic [15:0] src;
    logic        blk_a;
    logic        blk_b;
    logic        trip_sig;
    logic        mot_sig;
    logic        rev_sig;
    logic        glb_blk;
    logic        prot_ok;
    logic        glb_trip_blk;
    logic        freq_out;
    logic [7:0]  cell_active;
    logic [7:0]  cell_trip;
    logic [5:0]  widx;
    logic        in_mod;
    logic [2:0]  mod_idx;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign src      = {I_INT_SIG, I_DIG_IN};
    assign blk_a    = prbl_pkg::prbl_pick(src, st_q.gsel[prbl_pkg::GS_BLK_A +: 5]); // RULE7
    assign blk_b    = prbl_pkg::prbl_pick(src, st_q.gsel[prbl_pkg::GS_BLK_B +: 5]);
    assign trip_sig = prbl_pkg::prbl_pick(src, st_q.gsel[prbl_pkg::GS_TRIP +: 5]);
    assign mot_sig  = prbl_pkg::prbl_pick(src, st_q.gsel[prbl_pkg::GS_MOT +: 5]);
    assign rev_sig  = prbl_pkg::prbl_pick(src, st_q.rev_sel);

    // an unassigned input picks 0, so permit alone never blocks
    assign glb_blk      = st_q.gctrl[prbl_pkg::G_BLK_PERM] & (blk_a | blk_b);          // RULE4 RULE8
    assign prot_ok      = st_q.gctrl[prbl_pkg::G_PROT_EN] & ~glb_blk;                   // RULE1
    assign glb_trip_blk = st_q.gctrl[prbl_pkg::G_TRIP_PBLK]
                        | (st_q.gctrl[prbl_pkg::G_TRIP_PERM] & trip_sig);
    // only wide-range variants track frequency; others leave the bit clear
    assign freq_out     = st_q.gctrl[prbl_pkg::G_WIDE_FREQ] & ~I_FREQ_OK;              // RULE9

    for (genvar m = 0; m < prbl_pkg::N_MOD; m++) begin : g_cell
        prbl_cell u_cell (
            .i_ctrl         (st_q.mctrl[m]),
            .i_src          (src),
            .i_prot_ok      (prot_ok),
            .i_mot_strt     (mot_sig),
            .i_freq_out     (freq_out),
            .i_rev_il       (rev_sig),
            .i_glb_trip_blk (glb_trip_blk),
            .i_trip_dec     (I_TRIP_DEC[m]),
            .o_active       (cell_active[m]),
            .o_trip         (cell_trip[m])
        );
    end

    assign widx    = I_PADDR[7:2];
    assign in_mod  = (I_PADDR[11:2] >= prbl_pkg::OFS_MCTRL0[11:2]) && (I_PADDR[11:2] < prbl_pkg::OFS_REVSEL[11:2]);
    assign mod_idx = 3'(widx - prbl_pkg::OFS_MCTRL0[7:2]);

    always_comb begin
        logic        acc;
        logic        hit;
        logic [31:0] rd;
        st_d = st_q;
        acc  = I_PSEL & I_PENABLE;
        hit  = 1'b1;
        rd   = 32'h0000_0000;
        if (I_PADDR[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (I_PADDR == prbl_pkg::OFS_GCTRL) begin
            rd = st_q.gctrl;
        end else if (I_PADDR == prbl_pkg::OFS_GSEL) begin
            rd = st_q.gsel;
        end else if (in_mod) begin
            rd = st_q.mctrl[mod_idx];
        end else if (I_PADDR == prbl_pkg::OFS_REVSEL) begin
            rd = {27'h0000000, st_q.rev_sel};
        end else if (I_PADDR == prbl_pkg::OFS_STATUS) begin
            rd = {14'h0000, st_q.prot_blocked, st_q.prot_active, st_q.trip, st_q.active};
        end else begin
            hit = 1'b0;
        end
        // one wait state: the answer is registered, then the transfer completes
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        if (acc && !st_q.pready) begin
            st_d.pready  = 1'b1;
            st_d.pslverr = ~hit;
            st_d.prdata  = (I_PWRITE || !hit) ? 32'h0000_0000 : rd;
        end
        if (acc && st_q.pready && I_PWRITE && hit) begin
            if (I_PADDR == prbl_pkg::OFS_GCTRL) begin
                st_d.gctrl = merge(st_q.gctrl, I_PWDATA, I_PSTRB) & 32'h0000_001f;
            end else if (I_PADDR == prbl_pkg::OFS_GSEL) begin
                st_d.gsel = merge(st_q.gsel, I_PWDATA, I_PSTRB) & 32'h1f1f_1f1f;
            end else if (in_mod) begin
                st_d.mctrl[mod_idx] = merge(st_q.mctrl[mod_idx], I_PWDATA, I_PSTRB) & 32'h001f_1f7f;
            end else if (I_PADDR == prbl_pkg::OFS_REVSEL && I_PSTRB[0]) begin
                st_d.rev_sel = I_PWDATA[4:0];
            end
        end
        st_d.active       = cell_active;                                                // RULE2 RULE12
        st_d.trip         = cell_trip;                                                  // RULE3 RULE6
        st_d.prot_active  = prot_ok;                                                    // RULE1
        st_d.prot_blocked = glb_blk;                                                    // RULE4
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_q.gctrl        <= prbl_pkg::RST_GCTRL;
            st_q.gsel         <= prbl_pkg::RST_GSEL;
            st_q.mctrl        <= {prbl_pkg::N_MOD{prbl_pkg::RST_MCTRL}};
            st_q.rev_sel      <= prbl_pkg::RST_REVSEL;
            st_q.pready       <= 1'b0;
            st_q.pslverr      <= 1'b0;
            st_q.prdata       <= 32'h0000_0000;
            st_q.active       <= 8'h00;
            st_q.trip         <= 8'h00;
            st_q.prot_active  <= 1'b0;
            st_q.prot_blocked <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign O_PRDATA       = st_q.prdata;
    assign O_PREADY       = st_q.pready;
    assign O_PSLVERR      = st_q.pslverr;
    assign O_MOD_ACTIVE   = st_q.active;
    assign O_TRIP_CMD     = st_q.trip;
    assign O_PROT_ACTIVE  = st_q.prot_active;
    assign O_PROT_BLOCKED = st_q.prot_blocked;

    // helper vectors for the checks below
    logic [7:0] en_v;
    logic [7:0] pbk_v;
    logic [7:0] mblk_v;
    logic [7:0] tblk_v;
    logic [7:0] fund_v;
    logic [7:0] mot_v;
    logic [7:0] cur_v;
    for (genvar m = 0; m < prbl_pkg::N_MOD; m++) begin : g_chk
        assign en_v[m]   = st_q.mctrl[m][prbl_pkg::M_EN];
        assign pbk_v[m]  = st_q.mctrl[m][prbl_pkg::M_TRIP_PBK];
        assign mblk_v[m] = st_q.mctrl[m][prbl_pkg::M_BLK_PERM]
                         & prbl_pkg::prbl_pick(src, st_q.mctrl[m][prbl_pkg::M_BLK_SEL +: 5]);
        assign tblk_v[m] = st_q.mctrl[m][prbl_pkg::M_TRIP_PRM]
                         & prbl_pkg::prbl_pick(src, st_q.mctrl[m][prbl_pkg::M_TRIP_SEL +: 5]);
        assign fund_v[m] = st_q.mctrl[m][prbl_pkg::M_FUND];
        assign mot_v[m]  = st_q.mctrl[m][prbl_pkg::M_MOT_BLK];
        assign cur_v[m]  = st_q.mctrl[m][prbl_pkg::M_CURRENT];
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    a_global_off_stops: assert property ( // RULE1
        !st_q.gctrl[prbl_pkg::G_PROT_EN] |=> (O_MOD_ACTIVE == 8'h00 && O_TRIP_CMD == 8'h00 && !O_PROT_ACTIVE))
        else $error("protection off but active");
    a_module_off_inert: assert property (((O_MOD_ACTIVE | O_TRIP_CMD) & ~$past(en_v)) == 8'h00) // RULE2
        else $error("disabled module active");
    a_perm_trip_block: assert property ((O_TRIP_CMD & $past(pbk_v)) == 8'h00) // RULE3
        else $error("trip through permanent block");
    a_global_tmp_block: assert property ( // RULE4
        (st_q.gctrl[prbl_pkg::G_BLK_PERM] && (blk_a || blk_b))
        |=> (O_PROT_BLOCKED && !O_PROT_ACTIVE && O_MOD_ACTIVE == 8'h00))
        else $error("global block ignored");
    a_module_tmp_block: assert property ((O_MOD_ACTIVE & $past(mblk_v)) == 8'h00) // RULE5
        else $error("module block ignored");
    a_trip_tmp_block: assert property ((O_TRIP_CMD & $past(tblk_v)) == 8'h00) // RULE6
        else $error("trip block ignored");
    a_no_permit_free: assert property (!st_q.gctrl[prbl_pkg::G_BLK_PERM] |=> !O_PROT_BLOCKED) // RULE4
        else $error("blocked without permit");
    a_freq_fund_block: assert property ((O_MOD_ACTIVE & $past(fund_v) & {8{$past(freq_out)}}) == 8'h00) // RULE9
        else $error("fundamental element active off-frequency");
    a_motor_start_blk: assert property ((O_MOD_ACTIVE & $past(mot_v) & {8{$past(mot_sig)}}) == 8'h00) // RULE10
        else $error("motor start block ignored");
    a_reverse_ilock: assert property ((O_MOD_ACTIVE & $past(cur_v) & {8{$past(rev_sig)}}) == 8'h00) // RULE11
        else $error("reverse interlock ignored");
    a_active_needs_ok: assert property ((O_MOD_ACTIVE != 8'h00) |-> $past(prot_ok)) // RULE12
        else $error("module active while master down");
    a_src_selected: assert property ( // RULE7
        (st_q.gctrl[prbl_pkg::G_BLK_PERM] && st_q.gsel[prbl_pkg::GS_BLK_B +: 5] == 5'h09 && I_INT_SIG[0])
        |=> O_PROT_BLOCKED)
        else $error("internal source not honoured");
    a_apb_one_wait: assert property ((I_PSEL && I_PENABLE && !O_PREADY) |=> O_PREADY ##1 !O_PREADY)
        else $error("apb answer timing");

    c_global_block: cover property (O_PROT_ACTIVE ##1 O_PROT_BLOCKED);
    c_trip_issued: cover property (O_TRIP_CMD != 8'h00);
    c_mixed_state: cover property (O_MOD_ACTIVE != 8'h00 && O_MOD_ACTIVE != 8'hff && O_PROT_ACTIVE);
    c_slave_error: cover property (O_PREADY && O_PSLVERR);
endmodule

// ==== prbl_src_model.sv ====
// Purpose: far-side model of the assigned blocking sources and stage trip decisions
// Assumes: the bench sets the wanted levels; the model launches them on the clock
// Notes:   registered drive keeps pin changes away from the design's sampling edge
module prbl_src_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_dig,
    input  wire logic [7:0] i_int,
    input  wire logic       i_freq,
    input  wire logic [7:0] i_dec,
    output logic [7:0]      o_dig_in,
    output logic [7:0]      o_int_sig,
    output logic            o_freq_ok,
    output logic [7:0]      o_trip_dec
);
    timeunit 1ns;
    timeprecision 1ps;
    // digital inputs and internal signals are both offered as blocking sources
    always_ff @(posedge i_clk) begin
        o_dig_in   <= i_dig;
        o_int_sig  <= i_int;
        o_freq_ok  <= i_freq;
        o_trip_dec <= i_dec;
    end
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the protection blocking logic
// Assumes: one wait state on APB; blocking outputs lag their causes by one cycle
// Notes:   settle waits three edges to cover model launch plus design register
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] EN = 32'h1 << prbl_pkg::M_EN;
    logic        clk, rst_b, psel, pen, pwr, freq, freq_ok, pready, pslverr, p_act, p_blk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [7:0]  dig, int_s, dec, dig_in, int_sig, trip_dec, m_act, trip;
    int          errors, num_checks;

    prbl_src_model u_src (.i_clk(clk), .i_dig(dig), .i_int(int_s), .i_freq(freq), .i_dec(dec),
        .o_dig_in(dig_in), .o_int_sig(int_sig), .o_freq_ok(freq_ok), .o_trip_dec(trip_dec));
    prbl_top u_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .I_DIG_IN(dig_in), .I_INT_SIG(int_sig),
        .I_FREQ_OK(freq_ok), .I_TRIP_DEC(trip_dec), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_MOD_ACTIVE(m_act), .O_TRIP_CMD(trip), .O_PROT_ACTIVE(p_act),
        .O_PROT_BLOCKED(p_blk));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // holds the request until pready is sampled high; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= 4'hf;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check("write_err", {31'h0, e}, 32'h0);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r, exp);
        check("read_err", {31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic drive(input logic [7:0] dg, input logic [7:0] it, input logic fq);
        @(posedge clk);
        dig   <= dg;
        int_s <= it;
        freq  <= fq;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic expect_out(input logic [7:0] act, input logic [7:0] trp, input logic pa, input logic pb);
        check("mod_active", {24'h0, m_act}, {24'h0, act});
        check("trip_cmd", {24'h0, trip}, {24'h0, trp});
        check("prot_active", {31'h0, p_act}, {31'h0, pa});
        check("prot_blocked", {31'h0, p_blk}, {31'h0, pb});
    endtask

    task automatic all_on();
        for (int m = 0; m < prbl_pkg::N_MOD; m++) begin
            wr(prbl_pkg::OFS_MCTRL0 + 12'(4 * m), EN);
        end
        wr(prbl_pkg::OFS_GSEL, 32'h0);
        wr(prbl_pkg::OFS_GCTRL, 32'h1);
    endtask

    task automatic t_reset();
        rd_chk("gctrl", prbl_pkg::OFS_GCTRL, prbl_pkg::RST_GCTRL, 1'b0);
        rd_chk("gsel", prbl_pkg::OFS_GSEL, prbl_pkg::RST_GSEL, 1'b0);
        rd_chk("mctrl7", prbl_pkg::OFS_MCTRL0 + 12'h01c, prbl_pkg::RST_MCTRL, 1'b0);
        rd_chk("revsel", prbl_pkg::OFS_REVSEL, 32'h0, 1'b0);
        rd_chk("status", prbl_pkg::OFS_STATUS, 32'h1 << prbl_pkg::S_PROT_OK, 1'b0);
        expect_out(8'h00, 8'h00, 1'b1, 1'b0);
        rd_chk("unmapped", 12'h030, 32'h0, 1'b1);
        rd_chk("misaligned", 12'h001, 32'h0, 1'b1);
        wr(prbl_pkg::OFS_STATUS, 32'hffff_ffff);
        rd_chk("status_ro", prbl_pkg::OFS_STATUS, 32'h1 << prbl_pkg::S_PROT_OK, 1'b0);
    endtask

    task automatic t_enable();
        all_on();
        wr(prbl_pkg::OFS_MCTRL0 + 12'h00c, 32'h0);
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'hf7, 8'h00, 1'b1, 1'b0);
        dec <= 8'hff;
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'hf7, 8'hf7, 1'b1, 1'b0);
        wr(prbl_pkg::OFS_GCTRL, 32'h0);
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_global_block();
        all_on();
        wr(prbl_pkg::OFS_GSEL, (32'h1 << prbl_pkg::GS_BLK_A) | (32'h9 << prbl_pkg::GS_BLK_B));
        drive(8'h01, 8'h00, 1'b1);
        expect_out(8'hff, 8'hff, 1'b1, 1'b0);
        wr(prbl_pkg::OFS_GCTRL, 32'h3);
        drive(8'h01, 8'h00, 1'b1);
        expect_out(8'h00, 8'h00, 1'b0, 1'b1);
        drive(8'h00, 8'h01, 1'b1);
        expect_out(8'h00, 8'h00, 1'b0, 1'b1);
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'hff, 8'hff, 1'b1, 1'b0);
    endtask

    task automatic t_module_trip();
        all_on();
        // module 1 blocked by the last internal signal, module 4 trip by digital input 5
        wr(prbl_pkg::OFS_MCTRL0 + 12'h004, EN | 32'h2 | (32'h10 << prbl_pkg::M_BLK_SEL));
        wr(prbl_pkg::OFS_MCTRL0 + 12'h008, EN | (32'h1 << prbl_pkg::M_TRIP_PBK));
        wr(prbl_pkg::OFS_MCTRL0 + 12'h010, EN | 32'h8 | (32'h5 << prbl_pkg::M_TRIP_SEL));
        drive(8'h10, 8'h80, 1'b1);
        expect_out(8'hfd, 8'he9, 1'b1, 1'b0);
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'hff, 8'hfb, 1'b1, 1'b0);
        wr(prbl_pkg::OFS_GCTRL, 32'h5);
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'hff, 8'h00, 1'b1, 1'b0);
        // global temporary trip block from digital input 6
        wr(prbl_pkg::OFS_GSEL, 32'h6 << prbl_pkg::GS_TRIP);
        wr(prbl_pkg::OFS_GCTRL, 32'h9);
        drive(8'h20, 8'h00, 1'b1);
        expect_out(8'hff, 8'h00, 1'b1, 1'b0);
        drive(8'h00, 8'h00, 1'b1);
        expect_out(8'hff, 8'hfb, 1'b1, 1'b0);
    endtask

    task automatic t_special();
        all_on();
        wr(prbl_pkg::OFS_MCTRL0 + 12'h014, EN | (32'h1 << prbl_pkg::M_FUND));
        wr(prbl_pkg::OFS_MCTRL0 + 12'h018, EN | (32'h1 << prbl_pkg::M_MOT_BLK));
        wr(prbl_pkg::OFS_MCTRL0 + 12'h01c, EN | (32'h1 << prbl_pkg::M_CURRENT));
        wr(prbl_pkg::OFS_GSEL, 32'h2 << prbl_pkg::GS_MOT);
        wr(prbl_pkg::OFS_REVSEL, 32'h3);
        wr(prbl_pkg::OFS_GCTRL, 32'h11);
        drive(8'h00, 8'h00, 1'b0);
        expect_out(8'hdf, 8'hdf, 1'b1, 1'b0);
        drive(8'h02, 8'h00, 1'b1);
        expect_out(8'hbf, 8'hbf, 1'b1, 1'b0);
        drive(8'h04, 8'h00, 1'b1);
        expect_out(8'h7f, 8'h7f, 1'b1, 1'b0);
        rd_chk("status_act", prbl_pkg::OFS_STATUS, 32'h17f7f, 1'b0);
    endtask

    initial begin
        rst_b = 1'b0;
        {psel, pen, pwr, paddr, pwdata, pstrb} = '0;
        {dig, int_s, dec} = '0;
        freq = 1'b1;
        errors = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_enable();
        t_global_block();
        t_module_trip();
        t_special();
        test_done();
    end

    // the whole sequence takes a few hundred cycles
    initial begin
        #200000;
        errors++;
        test_done();
    end
endmodule
